// ===== src/canrc_consts.vh
// register map, field positions, reset values and timing for the can reset/config/irq block
`ifndef CANRC_CONSTS_VH
`define CANRC_CONSTS_VH

// register byte offsets
`define CANRC_OFS_MCTRL    8'h00
`define CANRC_OFS_GSTAT    8'h04
`define CANRC_OFS_IRQREQ   8'h08
`define CANRC_OFS_IRQMASK  8'h0C
`define CANRC_OFS_MBMASK   8'h10
`define CANRC_OFS_ERRCNT   8'h14

// master control register fields
`define CANRC_MC_RST_REQ   0
`define CANRC_MC_SLEEP     5

// general status register fields
`define CANRC_GS_BUS_OFF   0
`define CANRC_GS_PASSIVE   1
`define CANRC_GS_WARN      2
`define CANRC_GS_RST_STAT  3
`define CANRC_GS_BUS_ON    4

// interrupt request register fields
`define CANRC_IR_RST_PROC  0
`define CANRC_IR_TX_WARN   3
`define CANRC_IR_RX_WARN   4
`define CANRC_IR_PASSIVE   5
`define CANRC_IR_BUS_OFF   6
`define CANRC_IR_OVERLOAD  7
`define CANRC_IR_OVERRUN   9
`define CANRC_IR_WAKEUP    12
`define CANRC_IR_TMR_OVF   13
`define CANRC_IR_CMP_A     14
`define CANRC_IR_CMP_B     15

// groups feeding each interrupt line
`define CANRC_ERR_GROUP    16'h0078
`define CANRC_OVR_GROUP    16'hF281

// reset values
`define CANRC_MCTRL_RST    32'h0000_0001
`define CANRC_IRQMASK_RST  16'hFFFF
`define CANRC_MBMASK_RST   32'hFFFF_FFFF

// error counter thresholds
`define CANRC_WARN_LIM     9'h060
`define CANRC_PASSIVE_LIM  9'h080
`define CANRC_BUS_OFF_LIM  9'h100
`define CANRC_TEC_STEP     9'h008

// timing
`define CANRC_CLK_NS       10
`define CANRC_INT_RST_NS   200
`define CANRC_RECESSIVE    11

`endif

// ===== src/canrc_err_mon.v
// error counter threshold monitor
`timescale 1ns/1ns
`include "canrc_consts.vh"
module canrc_err_mon (
    // counters
    input  wire [8:0] transmit_error_counter,
    input  wire [8:0] receive_error_counter,
    // levels
    output wire       tx_warn,
    output wire       rx_warn,
    output wire       passive,
    output wire       bus_off
);
    assign tx_warn = (transmit_error_counter >= `CANRC_WARN_LIM);
    assign rx_warn = (receive_error_counter >= `CANRC_WARN_LIM);
    assign passive = (transmit_error_counter >= `CANRC_PASSIVE_LIM) | (receive_error_counter >= `CANRC_PASSIVE_LIM);
    assign bus_off = (transmit_error_counter >= `CANRC_BUS_OFF_LIM);
endmodule // canrc_err_mon

// ===== src/canrc_ctrl.v
// can controller reset, configuration mode and interrupt sources with axi4-lite registers
// How it works
// - any hardware reset or standby sets reset request and reset status automatically.
// - hardware reset reinitialises every register here but the register port, which only aresetn resets; mailbox storage lies elsewhere.
// - software reset request waits for an ongoing transmission or reception to finish.
// - software reset only proceeds once the controller has left bus-off.
// - software reset sets reset status and clears both error counters only.
// - clearing reset request runs an internal reset, then reset status clears itself.
// - after configuration, join the bus only after 11 consecutive recessive bits.
// - every flag is maskable except the power-on reset processing flag.
// - error passive flag when either error counter reaches 128; error line only.
// - bus-off flag when transmit counter reaches 256, and again on recovery.
// - separate warning flags for transmit and receive counters reaching 96.
// - power-on reset sets reset processing flag, shared on the overrun line.
// - bus activity seen during sleep mode sets the wakeup flag.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ns
`include "canrc_consts.vh"
module canrc_ctrl #(
    parameter ADDR_W         = 8,
    parameter RECESSIVE_BITS = `CANRC_RECESSIVE
) (
    // clock and reset (aresetn acts as the power-on reset)
    input  wire              aclk,
    input  wire              aresetn,
    // axi4-lite write address
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // axi4-lite read address
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // other reset sources, levels
    input  wire              manual_reset,
    input  wire              hw_standby,
    input  wire              sw_standby,
    // frame engine status and events
    input  wire              xfer_busy,
    input  wire              bit_tick,
    input  wire              can_rx,
    input  wire              tec_up,
    input  wire              tec_down,
    input  wire              rec_up,
    input  wire              rec_down,
    input  wire              busoff_recovered,
    input  wire              overload_sent,
    input  wire              overrun_evt,
    input  wire              timer_ovf,
    input  wire              cmp_a_match,
    input  wire              cmp_b_match,
    // status to the frame engine
    output wire              reset_status,
    output wire              bus_on,
    output wire              sleep_mode,
    // interrupt lines
    output wire              error_irq_line,
    output wire              overrun_irq_line,
    output wire              irq
);
    localparam [2:0] ST_CONFIG = 3'd0;
    localparam [2:0] ST_INTRST = 3'd1;
    localparam [2:0] ST_PWRUP  = 3'd2;
    localparam [2:0] ST_NORMAL = 3'd3;
    localparam [2:0] ST_SWPEND = 3'd4;
    localparam integer INT_RST_CYC = (`CANRC_INT_RST_NS + `CANRC_CLK_NS - 1) / `CANRC_CLK_NS;

    // byte-lane merge for partial writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0]  strb;
        integer      i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = wd[i*8 +: 8];
        end
    endfunction

    // saturating 9-bit counter step
    function [8:0] cnt_step;
        input [8:0] cnt;
        input       up;
        input [8:0] inc;
        input       down;
        reg   [9:0] sum;
        begin
            sum = {1'b0, cnt} + (up ? {1'b0, inc} : 10'h000);
            if (sum[9])
                cnt_step = 9'h1FF;
            else if (down && !up && cnt != 9'h000)
                cnt_step = cnt - 9'h001;
            else
                cnt_step = sum[8:0];
        end
    endfunction

    reg  [2:0]        state_r;
    reg  [2:0]        state_nxt;
    reg  [7:0]        dly_r;
    reg  [3:0]        rcsv_r;
    reg  [31:0]       mctrl_r;
    reg  [15:0]       irqreq_r;
    reg  [15:0]       irqmask_r;
    reg  [31:0]       mbmask_r;
    reg  [8:0]        tec_r;
    reg  [8:0]        rec_r;
    reg  [3:0]        lvl_r;
    reg               aw_full_r;
    reg  [ADDR_W-1:0] aw_addr_r;
    reg               w_full_r;
    reg  [31:0]       w_data_r;
    reg  [3:0]        w_strb_r;
    reg  [15:0]       irq_set;
    reg               wr_hit;
    reg  [31:0]       rd_val;
    reg               rd_hit;
    wire              tx_warn;
    wire              rx_warn;
    wire              passive;
    wire              bus_off;
    wire              hw_rst;
    wire              wr_go;
    wire              sw_init;
    wire [3:0]        lvl = {bus_off, passive, rx_warn, tx_warn};
    wire [15:0]       unmasked = irqreq_r & (~irqmask_r | 16'h0001); // flag 0 bypasses the mask
    wire [31:0]       mask_wr = merge({16'h0000, irqmask_r}, w_data_r, w_strb_r);
    wire [31:0]       clr_wr = merge(32'h0000_0000, w_data_r, w_strb_r);

    // power-on reset is aresetn; the others reinitialise the same state except the register port and the reset processing flag
    assign hw_rst = !aresetn | manual_reset | hw_standby | sw_standby;

    canrc_err_mon u_err_mon (
        .transmit_error_counter     (tec_r),
        .receive_error_counter     (rec_r),
        .tx_warn (tx_warn),
        .rx_warn (rx_warn),
        .passive (passive),
        .bus_off (bus_off)
    );

    // write path: address and data are taken in either order
    assign s_axi_awready = !aw_full_r;
    assign s_axi_wready  = !w_full_r;
    assign wr_go         = aw_full_r && w_full_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r    <= 1'b0;
            aw_addr_r    <= {ADDR_W{1'b0}};
            w_full_r     <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= 2'b00;
            s_axi_rdata  <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_r    <= 1'b0;
                w_full_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always @* begin
        case (aw_addr_r[7:0] & 8'hFC)
            `CANRC_OFS_MCTRL, `CANRC_OFS_GSTAT, `CANRC_OFS_IRQREQ,
            `CANRC_OFS_IRQMASK, `CANRC_OFS_MBMASK, `CANRC_OFS_ERRCNT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always @* begin
        rd_hit = 1'b1;
        case (s_axi_araddr[7:0] & 8'hFC)
            `CANRC_OFS_MCTRL:   rd_val = mctrl_r;
            `CANRC_OFS_GSTAT:   rd_val = {27'h000_0000, bus_on, reset_status, tx_warn | rx_warn, passive, bus_off};
            `CANRC_OFS_IRQREQ:  rd_val = {16'h0000, irqreq_r};
            `CANRC_OFS_IRQMASK: rd_val = {16'h0000, irqmask_r};
            `CANRC_OFS_MBMASK:  rd_val = mbmask_r;
            `CANRC_OFS_ERRCNT:  rd_val = {7'h00, rec_r, 7'h00, tec_r};
            default: begin
                rd_val = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // configuration and bus-join sequence
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_CONFIG:
                if (!mctrl_r[`CANRC_MC_RST_REQ])
                    state_nxt = ST_INTRST;
            ST_INTRST:
                if (mctrl_r[`CANRC_MC_RST_REQ])
                    state_nxt = ST_CONFIG;
                else if (dly_r == 8'h00)
                    state_nxt = ST_PWRUP;
            ST_PWRUP:
                if (mctrl_r[`CANRC_MC_RST_REQ])
                    state_nxt = ST_CONFIG;
                else if (bit_tick && can_rx && rcsv_r == RECESSIVE_BITS[3:0] - 4'd1)
                    state_nxt = ST_NORMAL;
            ST_NORMAL:
                if (mctrl_r[`CANRC_MC_RST_REQ])
                    state_nxt = ST_SWPEND;
            ST_SWPEND:
                if (!xfer_busy && !bus_off)
                    state_nxt = ST_CONFIG;
            default:
                state_nxt = ST_CONFIG;
        endcase
    end

    assign sw_init      = (state_r == ST_SWPEND) && (state_nxt == ST_CONFIG);
    assign reset_status = (state_r == ST_CONFIG) || (state_r == ST_INTRST);
    assign bus_on       = (state_r == ST_NORMAL) || (state_r == ST_SWPEND);
    assign sleep_mode   = mctrl_r[`CANRC_MC_SLEEP];

    always @(posedge aclk) begin
        if (hw_rst) begin
            state_r <= ST_CONFIG;
            dly_r   <= 8'h00;
            rcsv_r  <= 4'h0;
        end else begin
            state_r <= state_nxt;
            // internal reset takes a fixed time before status clears
            if (state_r != ST_INTRST)
                dly_r <= INT_RST_CYC[7:0] - 8'h01;
            else if (dly_r != 8'h00)
                dly_r <= dly_r - 8'h01;
            // any dominant bit restarts the recessive run
            if (state_r != ST_PWRUP)
                rcsv_r <= 4'h0;
            else if (bit_tick)
                rcsv_r <= can_rx ? rcsv_r + 4'h1 : 4'h0;
        end
    end

    // control, masks and error counters
    always @(posedge aclk) begin
        if (hw_rst) begin
            mctrl_r   <= `CANRC_MCTRL_RST;
            irqmask_r <= `CANRC_IRQMASK_RST;
            mbmask_r  <= `CANRC_MBMASK_RST;
            tec_r     <= 9'h000;
            rec_r     <= 9'h000;
        end else begin
            if (wr_go && (aw_addr_r[7:0] & 8'hFC) == `CANRC_OFS_MCTRL)
                mctrl_r <= merge(mctrl_r, w_data_r, w_strb_r) &
                           ((32'h1 << `CANRC_MC_RST_REQ) | (32'h1 << `CANRC_MC_SLEEP));
            if (wr_go && (aw_addr_r[7:0] & 8'hFC) == `CANRC_OFS_IRQMASK)
                irqmask_r <= mask_wr[15:0];
            if (wr_go && (aw_addr_r[7:0] & 8'hFC) == `CANRC_OFS_MBMASK)
                mbmask_r <= merge(mbmask_r, w_data_r, w_strb_r);
            if (sw_init || busoff_recovered) begin
                tec_r <= 9'h000;
                rec_r <= 9'h000;
            end else if (bus_on) begin
                tec_r <= cnt_step(tec_r, tec_up, `CANRC_TEC_STEP, tec_down);
                rec_r <= cnt_step(rec_r, rec_up, 9'h001, rec_down);
            end
        end
    end

    // interrupt request flags: rising threshold crossings and events
    always @* begin
        irq_set = 16'h0000;
        irq_set[`CANRC_IR_TX_WARN]  = tx_warn & !lvl_r[0];
        irq_set[`CANRC_IR_RX_WARN]  = rx_warn & !lvl_r[1];
        irq_set[`CANRC_IR_PASSIVE]  = passive & !lvl_r[2];
        irq_set[`CANRC_IR_BUS_OFF]  = (bus_off & !lvl_r[3]) | busoff_recovered;
        irq_set[`CANRC_IR_OVERLOAD] = overload_sent;
        irq_set[`CANRC_IR_OVERRUN]  = overrun_evt;
        irq_set[`CANRC_IR_WAKEUP]   = sleep_mode & !can_rx;
        irq_set[`CANRC_IR_TMR_OVF]  = timer_ovf;
        irq_set[`CANRC_IR_CMP_A]    = cmp_a_match;
        irq_set[`CANRC_IR_CMP_B]    = cmp_b_match;
    end

    always @(posedge aclk) begin
        if (hw_rst) begin
            // only a power-on reset raises the reset processing flag
            irqreq_r <= aresetn ? 16'h0000 : 16'h0001;
            lvl_r    <= 4'h0;
        end else begin
            lvl_r <= lvl;
            // set beats a simultaneous write-one-to-clear
            if (wr_go && (aw_addr_r[7:0] & 8'hFC) == `CANRC_OFS_IRQREQ)
                irqreq_r <= (irqreq_r & ~clr_wr[15:0]) | irq_set;
            else
                irqreq_r <= irqreq_r | irq_set;
        end
    end

    assign error_irq_line   = |(unmasked & `CANRC_ERR_GROUP);
    assign overrun_irq_line = |(unmasked & `CANRC_OVR_GROUP);
    assign irq              = error_irq_line | overrun_irq_line;
endmodule // canrc_ctrl

// ===== bench/canrc_checker.sv
// assertions for the can reset, configuration and interrupt block
`timescale 1ns/1ns
module canrc_checker (
    // clock and reset
    input wire        aclk,
    input wire        aresetn,
    // register bus handshakes
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    // reset sources and bus side
    input wire        manual_reset,
    input wire        hw_standby,
    input wire        sw_standby,
    input wire        xfer_busy,
    input wire        bit_tick,
    input wire        can_rx,
    // status and interrupt lines
    input wire        reset_status,
    input wire        bus_on,
    input wire        error_irq_line,
    input wire        overrun_irq_line,
    input wire        irq
);
    wire      hw_rst = manual_reset || hw_standby || sw_standby;
    // recessive run outside configuration; saturates so long idle cannot wrap
    reg [3:0] run_r;
    always @(posedge aclk) begin
        if (!aresetn || reset_status || (bit_tick && !can_rx))
            run_r <= 4'h0;
        else if (bit_tick && run_r != 4'hf)
            run_r <= run_r + 4'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_hw_reset_cfg:
        assert property (hw_rst |=> reset_status && !bus_on) else $error("reset source missed configuration");
    a_por_flag:
        assert property ($rose(aresetn) |-> overrun_irq_line) else $error("power-on flag line low");
    a_cfg_no_bus:
        assert property ($fell(reset_status) |-> $past(reset_status, 20) && !bus_on) else $error("configuration left early");
    a_join_after_run:
        assert property ($rose(bus_on) |-> run_r >= 4'hb) else $error("joined bus too early");
    a_sw_defer:
        assert property ($rose(reset_status) && !$past(hw_rst) |-> !$past(xfer_busy))
            else $error("software reset during transfer");
    a_irq_lines_or:
        assert property (irq == (error_irq_line || overrun_irq_line)) else $error("irq not or of lines");
    a_bvalid_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    a_rdata_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
            else $error("read data not held");
    a_read_latency:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule // canrc_checker
bind canrc_ctrl canrc_checker i_canrc_checker (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .manual_reset, .hw_standby, .sw_standby,
    .xfer_busy, .bit_tick, .can_rx, .reset_status, .bus_on, .error_irq_line, .overrun_irq_line, .irq);

// ===== bench/canrc_can_node.sv
// other can nodes: bit timing and frames of random bits
`timescale 1ns/1ns
module canrc_can_node (
    // clock and reset
    input  wire aclk,
    input  wire aresetn,
    // frame request
    input  wire start,
    // bus side
    output reg  bit_tick,
    output reg  can_rx,
    output reg  xfer_busy
);
    reg [1:0] div_r;
    reg [3:0] left_r;
    initial {bit_tick, can_rx, xfer_busy, div_r, left_r} = 9'h080;
    always @(posedge aclk) begin
        div_r <= aresetn ? div_r + 2'h1 : 2'h0;
        bit_tick <= aresetn && div_r == 2'h3;
        if (!aresetn) begin
            left_r <= 4'h0;
            can_rx <= 1'h1;
            xfer_busy <= 1'h0;
        end else if (start && left_r == 4'h0) begin
            left_r <= 4'hc;
            xfer_busy <= 1'h1;
            can_rx <= 1'h0;
        end else if (bit_tick && left_r != 4'h0) begin
            left_r <= left_r - 4'h1;
            xfer_busy <= left_r != 4'h1;
            can_rx <= left_r == 4'h1 ? 1'h1 : 1'($urandom);
        end
        // idle bus stays recessive between frames
    end
endmodule // canrc_can_node

// ===== bench/testbench.sv
// self-checking bench for the can reset, configuration and interrupt block
`timescale 1ns/1ns
module testbench;
    reg         aclk = 1'h0;
    reg         aresetn = 1'h0;
    reg  [7:0]  s_axi_awaddr = 8'h00;
    reg  [7:0]  s_axi_araddr = 8'h00;
    reg  [31:0] s_axi_wdata = 32'h0000_0000;
    reg  [3:0]  s_axi_wstrb = 4'hf;
    reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    reg  [2:0]  rs = 3'h0;
    reg  [4:0]  ev = 5'h00;
    reg         tec_up = 1'h0, rec_up = 1'h0, busoff_recovered = 1'h0, start = 1'h0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        bit_tick, can_rx, xfer_busy, reset_status, bus_on, sleep_mode, error_irq_line, overrun_irq_line, irq;
    integer     num_errors = 0, tests_run = 0, i;
    reg  [31:0] rnd, fl;
    reg  [33:0] wq[$], rq[$];
    canrc_ctrl i_canrc_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .manual_reset(rs[0]), .hw_standby(rs[1]), .sw_standby(rs[2]), .xfer_busy, .bit_tick, .can_rx, .tec_up,
        .tec_down(1'h0), .rec_up, .rec_down(1'h0), .busoff_recovered, .overload_sent(ev[0]), .overrun_evt(ev[1]),
        .timer_ovf(ev[2]), .cmp_a_match(ev[3]), .cmp_b_match(ev[4]), .reset_status, .bus_on, .sleep_mode,
        .error_irq_line, .overrun_irq_line, .irq);
    canrc_can_node i_canrc_can_node (.aclk, .aresetn, .start, .bit_tick, .can_rx, .xfer_busy);
    initial forever #5 aclk = ~aclk;
    task chk(input [63:0] nm, input [33:0] e, input [33:0] s);
        begin
            tests_run = tests_run + 1;
            if (s !== e) begin
                num_errors = num_errors + 1;
                $display("FAIL %0s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, num_errors);
            if (num_errors == 0 && tests_run > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // responses are judged where they appear, against notes queued by the driver
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", wq.pop_front(), {s_axi_bresp, 32'h0000_0000});
        if (s_axi_rvalid && s_axi_rready)
            chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    end
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
        reg aw, w;
        begin
            aw = 1'h1;
            w = 1'h1;
            wq.push_back({r, 32'h0000_0000});
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            while (aw || w) begin
                @(posedge aclk);
                if (aw && s_axi_awready) begin
                    s_axi_awvalid <= 1'h0;
                    aw = 1'h0;
                end
                if (w && s_axi_wready) begin
                    s_axi_wvalid <= 1'h0;
                    w = 1'h0;
                end
            end
            repeat ($urandom % 3) @(posedge aclk);
            s_axi_bready <= 1'h1;
            do @(posedge aclk); while (!s_axi_bvalid);
            s_axi_bready <= 1'h0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] d, input [1:0] r);
        begin
            rq.push_back({r, d});
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            do @(posedge aclk); while (!s_axi_arready);
            s_axi_arvalid <= 1'h0;
            repeat ($urandom % 3) @(posedge aclk);
            s_axi_rready <= 1'h1;
            do @(posedge aclk); while (!s_axi_rvalid);
            s_axi_rready <= 1'h0;
        end
    endtask
    task lines(input [1:0] e);
        begin
            repeat (2) @(negedge aclk);
            chk("lines", {32'h0000_0000, e}, {32'h0000_0000, error_irq_line, overrun_irq_line});
        end
    endtask
    task pulses(input t, input integer n);
        repeat (n) begin
            @(posedge aclk);
            tec_up <= t;
            rec_up <= !t;
            @(posedge aclk);
            tec_up <= 1'h0;
            rec_up <= 1'h0;
        end
    endtask
    task frame;
        begin
            @(posedge aclk);
            start <= 1'h1;
            @(posedge aclk);
            start <= 1'h0;
            // lets xfer_busy rise before a caller polls it
            @(posedge aclk);
        end
    endtask
    initial begin
        #200000;
        num_errors = num_errors + 1;
        end_of_test;
    end
    initial begin
        rnd = $urandom(58);
        rnd = $urandom;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        rd(8'h00, 32'h0000_0001, 2'h0);
        rd(8'h04, 32'h0000_0008, 2'h0);
        rd(8'h08, 32'h0000_0001, 2'h0);
        rd(8'h0C, 32'h0000_FFFF, 2'h0);
        rd(8'h10, 32'hFFFF_FFFF, 2'h0);
        rd(8'h14, 32'h0000_0000, 2'h0);
        rd(8'h18, 32'h0000_0000, 2'h2);
        lines(2'h1);
        wr(8'h08, 32'h0000_0001, 2'h0);
        lines(2'h0);
        wr(8'h10, rnd, 2'h0);
        wr(8'h04, 32'hFFFF_FFFF, 2'h0);
        rd(8'h04, 32'h0000_0008, 2'h0);
        wr(8'h0C, 32'h0000_0000, 2'h0);
        wr(8'h00, 32'h0000_0000, 2'h0);
        frame;
        chk("cfg", 34'h1, {33'h0, reset_status});
        while (!bus_on) @(posedge aclk);
        rd(8'h04, 32'h0000_0010, 2'h0);
        for (i = 0; i < 5; i = i + 1) begin
            fl = 32'h0000_0001 << (i == 0 ? 7 : i == 1 ? 9 : 11 + i);
            @(posedge aclk);
            ev <= 5'h01 << i;
            @(posedge aclk);
            ev <= 5'h00;
            lines(2'h1);
            rd(8'h08, fl, 2'h0);
            wr(8'h08, fl, 2'h0);
        end
        wr(8'h0C, 32'h0000_0080, 2'h0);
        ev <= 5'h01;
        @(posedge aclk);
        ev <= 5'h00;
        lines(2'h0);
        rd(8'h08, 32'h0000_0080, 2'h0);
        wr(8'h08, 32'h0000_0080, 2'h0);
        wr(8'h00, 32'h0000_0020, 2'h0);
        chk("sleep", 34'h1, {33'h0, sleep_mode});
        frame;
        while (xfer_busy) @(posedge aclk);
        rd(8'h08, 32'h0000_1000, 2'h0);
        wr(8'h08, 32'h0000_1000, 2'h0);
        wr(8'h00, 32'h0000_0000, 2'h0);
        pulses(1'h1, 12);
        lines(2'h2);
        pulses(1'h0, 128);
        rd(8'h08, 32'h0000_0038, 2'h0);
        rd(8'h14, 32'h0080_0060, 2'h0);
        rd(8'h04, 32'h0000_0016, 2'h0);
        pulses(1'h1, 20);
        rd(8'h08, 32'h0000_0078, 2'h0);
        wr(8'h08, 32'h0000_0078, 2'h0);
        lines(2'h0);
        wr(8'h00, 32'h0000_0001, 2'h0);
        repeat (10) @(negedge aclk);
        chk("busoff", 34'h0, {33'h0, reset_status});
        frame;
        busoff_recovered <= 1'h1;
        @(posedge aclk);
        busoff_recovered <= 1'h0;
        lines(2'h2);
        chk("busy", 34'h0, {33'h0, reset_status});
        while (xfer_busy) @(posedge aclk);
        rd(8'h04, 32'h0000_0008, 2'h0);
        rd(8'h14, 32'h0000_0000, 2'h0);
        rd(8'h10, rnd, 2'h0);
        s_axi_wstrb <= 4'h2;
        wr(8'h10, 32'h0000_5A00, 2'h0);
        s_axi_wstrb <= 4'hf;
        rd(8'h10, {rnd[31:16], 8'h5A, rnd[7:0]}, 2'h0);
        for (i = 0; i < 3; i = i + 1) begin
            wr(8'h10, 32'h0000_0000, 2'h0);
            rs <= 3'h1 << i;
            @(posedge aclk);
            rs <= 3'h0;
            rd(8'h00, 32'h0000_0001, 2'h0);
            rd(8'h08, 32'h0000_0000, 2'h0);
            rd(8'h10, 32'hFFFF_FFFF, 2'h0);
        end
        end_of_test;
    end
endmodule // testbench
